// ===== core/uls_phy_link.sv
// Link-facing digital signalling of a ULPI transceiver: bus ownership, pacing, stop
// handling, clock mode strap and chip reset behaviour.
// Assumes the link meets the ULPI protocol on the far side and that ref_clk models the
// interface clock; rstn is the active-low chip reset and may change at any time.
//
// Contract
// R1: With bytes waiting for the link, the transceiver raises DIR before it drives the bus.
// R2: With nothing to send, DIR stays low, the bus is left to the link and watched for commands.
// R3: In clock-output mode the interface clock is generated and every output changes on its rising edge.
// R4: A clock output pin found strapped high selects clock-input mode and is never driven.
// R5: In clock-input mode the link supplies the interface clock that times the whole interface.
// R6: While the link transmits, NXT is high in each cycle in which the presented byte is taken.
// R7: The data bus is eight bits wide, bit 0 the least and bit 7 the most significant.
// R8: The link ends the current stream by holding STP high for exactly one clock cycle.
// R9: In a transfer from the link, the byte seen in the cycle before STP is the final byte.
// R10: While chip reset is low the part stays suspended with regulators off and resumes when it rises.
// R11: Chip reset may change at any moment with no timing relation to any clock.
// R12: After chip reset is released all interface state returns to defaults and every state machine restarts.
// R13: While chip reset is low every ULPI pin is in high impedance.
// R14: Each change of DIR is followed by one turnaround cycle in which nobody drives the bus.
`timescale 1ns/1ps

module uls_phy_link (
  // Clock and chip reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // ULPI control and data pins toward the link
  input  wire logic                     stp,
  input  wire logic [uls_pkg::ULPI_W-1:0] data_in,
  output uls_pkg::uls_pins_s            pins,
  // Clock output pin, also read as the mode strap
  input  wire logic                     interface_clock_out_in,
  output logic                          interface_clock_out_o,
  output logic                          interface_clock_out_oe,
  // Power and mode status
  output logic                          suspended,
  output logic                          regulators_en,
  output logic                          clock_in_mode,
  // Bytes from the transceiver core toward the link
  input  uls_pkg::uls_byte_s            up_byte,
  output logic                          up_ready,
  // Bytes received from the link
  output uls_pkg::uls_byte_s            dn_byte
);
  import uls_pkg::*;

  function automatic logic is_cmd(input logic [ULPI_W-1:0] b);
    is_cmd = (b != BUS_IDLE);
  endfunction

  // Reset release synchroniser; assertion stays asynchronous so pins float at once.
  logic [1:0]  rst_sync_reg;
  logic        run;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= SYNC_RST; // R11
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1}; // R11
    end
  end

  assign run = rst_sync_reg[1];

  // Strap and power state.
  logic        strap_done_reg;
  logic        strap_done_next;
  logic        clk_in_mode_reg;
  logic        clk_in_mode_next;
  logic        clk_out_reg;
  logic        clk_out_next;
  logic        clk_oe_reg;
  logic        clk_oe_next;
  logic        awake_reg;
  logic        awake_next;
  logic        suspended_reg;
  logic        suspended_next;

  // The strap is read one cycle after the synchronised release, while the pin is still undriven.
  assign strap_done_next  = strap_done_reg | run;
  assign clk_in_mode_next = (run && !strap_done_reg) ? interface_clock_out_in
                                                     : clk_in_mode_reg; // R4
  assign clk_oe_next      = strap_done_reg & ~clk_in_mode_reg; // R4 R13
  // The toggle marks the interface clock edges; a real part drives the PLL output here.
  assign clk_out_next     = clk_oe_next ? ~clk_out_reg : 1'b0; // R3
  assign awake_next       = run; // R10
  assign suspended_next   = ~run; // R10

  // Bus ownership sequence.
  uls_state_e  state_reg;
  uls_state_e  state_next;
  logic        dir_reg;
  logic        dir_next;
  logic        nxt_reg;
  logic        nxt_next;
  logic [ULPI_W-1:0] data_out_reg;
  logic [ULPI_W-1:0] data_out_next;
  logic        data_oe_reg;
  logic        data_oe_next;
  logic        ctl_oe_reg;
  logic        ctl_oe_next;
  logic        up_ready_reg;
  logic        up_ready_next;
  logic        sent_last_reg;
  logic        sent_last_next;
  logic        load;
  logic        ready;

  assign ready = run & strap_done_reg;
  assign load  = up_ready_reg & up_byte.valid;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ULS_IDLE: begin
        if (ready && up_byte.valid) begin
          state_next = ULS_TURN_UP; // R1
        end else if (ready && is_cmd(data_in)) begin
          state_next = ULS_RECV; // R2
        end
      end
      ULS_TURN_UP: begin
        state_next = ULS_SEND; // R14
      end
      ULS_SEND: begin
        if (stp || sent_last_reg) begin
          state_next = ULS_TURN_DN; // R14
        end
      end
      ULS_TURN_DN: begin
        state_next = ULS_IDLE; // R14
      end
      ULS_RECV: begin
        if (stp) begin
          state_next = ULS_IDLE; // R8
        end
      end
      default: begin
        state_next = ULS_IDLE;
      end
    endcase
  end

  assign sent_last_next = (state_next != ULS_SEND) ? 1'b0
                        : (load ? up_byte.last : sent_last_reg);
  assign dir_next       = (state_next == ULS_TURN_UP) || (state_next == ULS_SEND); // R1 R2
  // Bus is driven only in SEND, so the cycle after each DIR edge is undriven.
  assign data_oe_next   = (state_next == ULS_SEND); // R1 R14
  assign data_out_next  = load ? up_byte.data : data_out_reg; // R7
  assign up_ready_next  = ((state_next == ULS_TURN_UP) || (state_next == ULS_SEND))
                        && !sent_last_next;
  assign nxt_next       = (state_next == ULS_RECV) || ((state_next == ULS_SEND) && load); // R6
  assign ctl_oe_next    = run; // R13

  // Receive path: a byte is held until the next cycle shows whether STP follows it.
  logic        pend_valid_reg;
  logic        pend_valid_next;
  logic [ULPI_W-1:0] pend_data_reg;
  logic [ULPI_W-1:0] pend_data_next;
  uls_byte_s   dn_reg;
  uls_byte_s   dn_next;
  logic        in_recv;
  logic        accept;

  assign in_recv = (state_reg == ULS_RECV);
  assign accept  = in_recv & nxt_reg & ~stp; // R6

  always_comb begin
    dn_next         = '0;
    pend_valid_next = pend_valid_reg;
    pend_data_next  = pend_data_reg;
    if (in_recv && stp) begin
      dn_next.valid   = pend_valid_reg; // R9
      dn_next.last    = pend_valid_reg; // R9
      dn_next.data    = pend_data_reg;
      pend_valid_next = 1'b0;
    end else if (accept) begin
      dn_next.valid   = pend_valid_reg;
      dn_next.data    = pend_data_reg;
      pend_valid_next = 1'b1;
      pend_data_next  = data_in; // R7
    end else if (!in_recv) begin
      pend_valid_next = 1'b0;
    end
  end

  // Every flop but rst_sync_reg takes its reset value at once on chip reset and keeps it until the synchronised release.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_reg  <= 1'b0; // R12
      clk_in_mode_reg <= MODE_RST;
      clk_out_reg     <= 1'b0;
      clk_oe_reg      <= 1'b0; // R13
      awake_reg       <= 1'b0; // R10
      suspended_reg   <= 1'b1; // R10
    end else begin
      strap_done_reg  <= strap_done_next;
      clk_in_mode_reg <= clk_in_mode_next;
      clk_out_reg     <= clk_out_next;
      clk_oe_reg      <= clk_oe_next;
      awake_reg       <= awake_next;
      suspended_reg   <= suspended_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ULS_IDLE; // R12
      dir_reg       <= DIR_RST;
      nxt_reg       <= NXT_RST;
      data_out_reg  <= DATA_RST;
      data_oe_reg   <= 1'b0; // R13
      ctl_oe_reg    <= 1'b0; // R13
      up_ready_reg  <= 1'b0;
      sent_last_reg <= 1'b0;
    end else begin
      state_reg     <= state_next; // R3
      dir_reg       <= dir_next;
      nxt_reg       <= nxt_next;
      data_out_reg  <= data_out_next;
      data_oe_reg   <= data_oe_next;
      ctl_oe_reg    <= ctl_oe_next;
      up_ready_reg  <= up_ready_next;
      sent_last_reg <= sent_last_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid_reg <= 1'b0; // R12
      pend_data_reg  <= DATA_RST;
      dn_reg         <= '0;
    end else begin
      pend_valid_reg <= pend_valid_next;
      pend_data_reg  <= pend_data_next;
      dn_reg         <= dn_next;
    end
  end

  assign pins.dir               = dir_reg;
  assign pins.nxt               = nxt_reg;
  assign pins.data              = data_out_reg;
  assign pins.data_oe           = data_oe_reg;
  assign pins.ctl_oe            = ctl_oe_reg;
  assign interface_clock_out_o  = clk_out_reg;
  assign interface_clock_out_oe = clk_oe_reg;
  assign suspended              = suspended_reg; // R10
  assign regulators_en          = awake_reg; // R10
  assign clock_in_mode          = clk_in_mode_reg;
  assign up_ready               = up_ready_reg;
  assign dn_byte                = dn_reg;

endmodule

// ===== core/uls_pkg.sv
// Shared constants and carrier types for the ULPI transceiver link-side signalling.
// Assumes one 40 MHz system clock that stands in for the ULPI interface clock.
package uls_pkg;

  // Bus geometry: DATA[0] is the LSB, DATA[7] the MSB.
  localparam int          ULPI_W        = 8;
  localparam logic [7:0]  BUS_IDLE      = 8'h00;

  // Clock figures.
  localparam int          IFC_CLK_MHZ   = 60;
  localparam int          REF_CLK_NS    = 25;

  // Least low time of the chip reset, and its count of ref_clk cycles, rounded up.
  localparam int          RESET_MIN_NS  = 1000;
  localparam int          RESET_MIN_CYC = (RESET_MIN_NS + REF_CLK_NS - 1) / REF_CLK_NS;

  // Values after reset.
  localparam logic        DIR_RST       = 1'b0;
  localparam logic        NXT_RST       = 1'b0;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic        MODE_RST      = 1'b0;
  localparam logic [1:0]  SYNC_RST      = 2'h0;

  // Bus ownership sequence, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ULS_IDLE    = 3'h0,
    ULS_TURN_UP = 3'h1,
    ULS_SEND    = 3'h3,
    ULS_TURN_DN = 3'h2,
    ULS_RECV    = 3'h6
  } uls_state_e;

  // Pins the transceiver drives toward the link.
  typedef struct packed {
    logic             dir;
    logic             nxt;
    logic [ULPI_W-1:0] data;
    logic             data_oe;
    logic             ctl_oe;
  } uls_pins_s;

  // One byte on the user side, either direction.
  typedef struct packed {
    logic             valid;
    logic             last;
    logic [ULPI_W-1:0] data;
  } uls_byte_s;

endpackage

// ===== testbench/uls_link_model.sv
// Behavioural link controller on the far side of the ULPI bus.
// Assumes send() and stop_pulse() are called at a falling edge of ref_clk.
`timescale 1ns/1ps
module uls_link_model (
  // Clock and device pins
  input wire logic                   ref_clk,
  input uls_pkg::uls_pins_s          pins,
  // Resolved bus and stop
  output logic [uls_pkg::ULPI_W-1:0] data_in,
  output logic                       stp
);
  import uls_pkg::*;
  logic [ULPI_W-1:0] drv     = BUS_IDLE;
  logic [ULPI_W-1:0] last_v  = BUS_IDLE;
  logic              link_oe = 1'b0;
  logic              hung    = 1'b0;
  logic [ULPI_W-1:0] rx_q[$];
  initial stp = 1'b0;
  // The link takes the bus back one cycle after DIR falls, leaving a turnaround.
  always @(posedge ref_clk) begin
    link_oe <= !pins.dir;
    last_v <= data_in;
    if (pins.dir && pins.data_oe && pins.nxt) rx_q.push_back(data_in);
  end
  // A floating bus flips every cycle, so stale data never passes for a match.
  // The link lets go of the bus at once when DIR rises, so TURN_UP is undriven too.
  assign data_in = pins.data_oe ? pins.data
                                : ((link_oe && !pins.dir) ? drv : ~last_v);
  task automatic send(input logic [ULPI_W-1:0] b[4]);
    int k;
    drv = b[0];
    k = 0;
    while (pins.nxt !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    hung = (k == 20);
    for (int i = 1; i < 4; i++) begin
      @(negedge ref_clk);
      drv = b[i];
    end
    @(negedge ref_clk);
    stp = 1'b1;
    drv = BUS_IDLE;
    @(negedge ref_clk);
    stp = 1'b0;
  endtask
  // A bare stop of one cycle, used to cut a stream the transceiver is sending.
  task automatic stop_pulse;
    stp = 1'b1;
    @(negedge ref_clk);
    stp = 1'b0;
  endtask
endmodule

// ===== testbench/uls_phy_link_props.sv
// Concurrent checks on the ULPI transceiver signalling ports.
// Assumes a bind onto uls_phy_link, whose only clock is ref_clk.
`timescale 1ns/1ps
module uls_phy_link_props (
  // Watched ports
  input wire logic                        ref_clk,
  input wire logic                        rstn,
  input wire logic                        stp,
  input wire logic [uls_pkg::ULPI_W-1:0]  data_in,
  input uls_pkg::uls_pins_s               pins,
  input wire logic                        interface_clock_out_in,
  input wire logic                        interface_clock_out_o,
  input wire logic                        interface_clock_out_oe,
  input wire logic                        suspended,
  input wire logic                        regulators_en,
  input wire logic                        clock_in_mode,
  input uls_pkg::uls_byte_s               up_byte,
  input wire logic                        up_ready,
  input uls_pkg::uls_byte_s               dn_byte
);
  import uls_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_asleep_quiet: assert property (
    suspended |-> !pins.ctl_oe && !pins.data_oe && !interface_clock_out_oe)
    else $error("pin driven while suspended");
  a_regs_match: assert property (
    regulators_en == !suspended) else $error("regulator enable wrong");
  a_bus_owner: assert property (
    pins.data_oe |-> pins.dir && pins.ctl_oe) else $error("data driven without dir");
  a_dir_cause: assert property (
    $rose(pins.dir) |-> $past(up_byte.valid) && !pins.data_oe)
    else $error("dir rose without request or turnaround");
  a_dir_stay: assert property (
    !pins.dir && !up_byte.valid |=> !pins.dir) else $error("dir rose with nothing to send");
  a_send_byte: assert property (
    pins.dir && up_ready && up_byte.valid && !stp |=>
      pins.data_oe && pins.nxt && pins.data == $past(up_byte.data))
    else $error("sent byte wrong");
  a_recv_byte: assert property (
    !pins.dir && pins.nxt && !stp && $past(pins.nxt) && !$past(pins.dir) && !$past(stp)
      |=> dn_byte.valid && !dn_byte.last && dn_byte.data == $past(data_in, 2))
    else $error("received byte wrong");
  a_recv_last: assert property (
    !pins.dir && pins.nxt && stp && $past(pins.nxt) && !$past(pins.dir) && !$past(stp)
      |=> dn_byte.valid && dn_byte.last && dn_byte.data == $past(data_in, 2))
    else $error("final byte wrong");
  a_clk_toggle: assert property (
    interface_clock_out_oe && $past(interface_clock_out_oe) |->
      interface_clock_out_o != $past(interface_clock_out_o))
    else $error("clock output stuck");
  a_strap_high: assert property (
    clock_in_mode |-> !interface_clock_out_oe) else $error("strapped pin driven");
  c_send: cover property ($rose(pins.dir));
  c_recv_end: cover property (dn_byte.valid && dn_byte.last);
  c_clk_in: cover property ($rose(clock_in_mode));
endmodule
bind uls_phy_link uls_phy_link_props u_uls_phy_link_props (.*);

// ===== testbench/uls_phy_link_tb.sv
// Self-checking bench for the ULPI transceiver link-side signalling.
// Assumes uls_link_model on the far side and the bound checker.
`timescale 1ns/1ps
module uls_phy_link_tb;
  import uls_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn    = 1'b0;
  logic              strap   = 1'b0;
  uls_byte_s         up_byte = '0;
  uls_pins_s         pins;
  uls_byte_s         dn_byte;
  logic              stp, clk_o, clk_oe, clk_pin, susp, reg_en, cin_mode, up_ready, dn_last;
  logic [ULPI_W-1:0] data_in;
  logic [ULPI_W-1:0] rows [4] = '{8'h01, 8'h80, 8'ha5, 8'h5a};
  logic [ULPI_W-1:0] dn_q[$];
  int                err_count = 0;
  int                compares = 0;
  // In clock-input mode the link supplies this clock.
  always #12.5 ref_clk = ~ref_clk;
  assign clk_pin = clk_oe ? clk_o : strap;
  always @(negedge ref_clk) if (dn_byte.valid === 1'b1) begin
    dn_q.push_back(dn_byte.data);
    dn_last <= dn_byte.last;
  end
  uls_phy_link u_uls_phy_link (.ref_clk(ref_clk), .rstn(rstn), .stp(stp), .data_in(data_in),
    .pins(pins), .interface_clock_out_in(clk_pin), .interface_clock_out_o(clk_o),
    .interface_clock_out_oe(clk_oe), .suspended(susp), .regulators_en(reg_en),
    .clock_in_mode(cin_mode), .up_byte(up_byte), .up_ready(up_ready), .dn_byte(dn_byte));
  uls_link_model u_uls_link_model (.ref_clk(ref_clk), .pins(pins), .data_in(data_in),
    .stp(stp));
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic push(input logic [ULPI_W-1:0] b, input logic l);
    int k;
    up_byte = {1'b1, l, b};
    k = 0;
    while (up_ready !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 20) begin
      err_count++;
      final_report;
    end
    @(negedge ref_clk);
  endtask
  task automatic do_reset(input logic s, input int n);
    logic v;
    rstn = 1'b0;
    strap = s;
    repeat (n) @(negedge ref_clk);
    cmp8("sleep state", 8'h80, {susp, reg_en, up_ready, pins.ctl_oe, pins.data_oe, clk_oe, pins.dir, 1'b0});
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    cmp8("awake state", {6'h00, s, 1'b0}, {susp, reg_en, 4'h0, cin_mode, pins.dir} ^ 8'h40);
    v = clk_o;
    @(negedge ref_clk);
    cmp1("clock pin toggles", ~s, (clk_o ^ v) & clk_oe);
  endtask
  initial begin
    do_reset(1'b0, 10);
    for (int i = 0; i < 4; i++) begin
      push(rows[i], i == 3);
    end
    up_byte = '0;
    repeat (4) @(negedge ref_clk);
    cmp1("dir idle", 1'b0, pins.dir);
    cmp8("tx count", 8'h04, 8'(u_uls_link_model.rx_q.size()));
    for (int i = 0; i < 4; i++) begin
      cmp8("tx byte", rows[i], u_uls_link_model.rx_q[i]);
    end
    u_uls_link_model.send(rows);
    repeat (3) @(negedge ref_clk);
    cmp1("link stalled", 1'b0, u_uls_link_model.hung);
    cmp8("rx count", 8'h04, 8'(dn_q.size()));
    for (int i = 0; i < 4; i++) begin
      cmp8("rx byte", rows[i], dn_q[i]);
    end
    cmp1("final flag", 1'b1, dn_last);
    push(rows[1], 1'b0);
    up_byte = '0;
    u_uls_link_model.stop_pulse();
    cmp8("stop ends send", 8'h00, {6'h00, pins.dir, up_ready});
    push(rows[0], 1'b0);
    #3 rstn = 1'b0;
    #1 cmp1("bus freed in reset", 1'b0, pins.dir | pins.ctl_oe | pins.data_oe);
    up_byte = '0;
    @(negedge ref_clk);
    do_reset(1'b1, RESET_MIN_CYC);
    final_report;
  end
endmodule
